//--- hw/wdg_pkg.sv
// ----------------------------------------------------------------
// shared constants of the watchdog
// ----------------------------------------------------------------
package wdg_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] SERVICE_ADDR = 8'ha6; // write-only
	localparam logic [7:0] PERIOD_ADDR  = 8'ha7; // period select
	localparam logic [7:0] ARM_FIRST    = 8'h1e; // first service byte
	localparam logic [7:0] ARM_SECOND   = 8'he1; // second service byte
	localparam logic [7:0] READ_ZERO    = 8'h00; // unmapped answer

	// period register layout
	localparam int         SEL_W     = 3;      // time-out select width
	localparam int         SEL_LSB   = 0;      // field position
	localparam logic [2:0] SEL_RESET = 3'h0;   // shortest period
	localparam int         ARMED_BIT = 7;      // read-only status bit
	localparam logic [3:0] PAD_ZERO  = 4'h0;   // spare bits read as 0

	// ------------------------------------------------------------
	// counter structure
	// ------------------------------------------------------------
	localparam int          PRESC_W    = 14;   // prescaler width
	localparam int          PROG_W     = 7;    // programmable counter
	localparam int          CNT_W      = PRESC_W + PROG_W;
	localparam logic [2:0]  PHASE_LAST = 3'h5; // six watchdog clocks per step
	localparam logic [2:0]  PHASE_ZERO = 3'h0;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int OSC_PERIOD_NS = 8;   // oscillator = CLK
	localparam int CLK_PERIOD_NS = 8;   // 125 MHz
	localparam int RST_PULSE_OSC = 96;  // pulse length, osc periods
	localparam int RST_PULSE_CYC =
		(RST_PULSE_OSC * OSC_PERIOD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int PULSE_W = 7;         // holds RST_PULSE_CYC
	localparam logic [PULSE_W-1:0] PULSE_LOAD =
		PULSE_W'(RST_PULSE_CYC);
	localparam logic [PULSE_W-1:0] PULSE_ZERO = 7'h00;

	// service sequence detector states
	typedef enum logic [1:0] {
		SEQ_IDLE  = 2'b01,
		SEQ_FIRST = 2'b10
	} wdg_seq_t;

endpackage

//--- hw/wdg_tick_gen.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// watchdog clock and six-phase step generator
// ----------------------------------------------------------------
module wdg_tick_gen (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic run,          // armed and not powered down
	input  wire logic clear,        // restart the phase
	input  wire logic halve_select, // fixed osc/2 clock
	input  wire logic double_speed, // core in double-speed mode
	output logic      tick          // one counter step
);
	logic       half;   // osc/2 toggle
	logic       wd_en;  // one watchdog clock edge
	logic [2:0] phase;  // 0..5 phase count

	// osc/2 unless double speed without the halve select
	assign wd_en = (halve_select || !double_speed) ? half : 1'b1;

	// divider toggles only while running, so power-down freezes it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			half <= 1'b0;
		end else if (clear) begin
			half <= 1'b0;
		end else if (run) begin
			half <= ~half;
		end
	end

	// phase counter, one step per six watchdog clocks
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase <= wdg_pkg::PHASE_ZERO;
			tick  <= 1'b0;
		end else if (clear) begin
			phase <= wdg_pkg::PHASE_ZERO;
			tick  <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (run && wd_en) begin
				if (phase == wdg_pkg::PHASE_LAST) begin
					phase <= wdg_pkg::PHASE_ZERO;
					tick  <= 1'b1;
				end else begin
					phase <= phase + 3'h1;
				end
			end
		end
	end

	// halved clock never steps on two adjacent edges
	property p_halved_rate;
		@(posedge clk) disable iff (!resetn)
		(tick && (halve_select || !double_speed) && !clear)
			|=> !tick;
	endproperty
	a_halved_rate: assert property (p_halved_rate)
		else $error("watchdog stepped faster than osc/2");
endmodule

//--- hw/wdg_pulse_gen.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// fixed-length chip reset pulse
// ----------------------------------------------------------------
module wdg_pulse_gen (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic start, // overflow seen
	output logic      pulse  // high while reset is forced
);
	logic [wdg_pkg::PULSE_W-1:0] remain; // cycles left
	logic [wdg_pkg::PULSE_W-1:0] width;  // helper for the check

	// load on start, count down to zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			remain <= wdg_pkg::PULSE_ZERO;
			pulse  <= 1'b0;
		end else if (start) begin
			remain <= wdg_pkg::PULSE_LOAD - 7'h01;
			pulse  <= 1'b1;
		end else if (remain != wdg_pkg::PULSE_ZERO) begin
			remain <= remain - 7'h01;
		end else begin
			pulse  <= 1'b0;
		end
	end

	// measured pulse width, read only by the check below
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			width <= wdg_pkg::PULSE_ZERO;
		end else if (pulse) begin
			width <= width + 7'h01;
		end else begin
			width <= wdg_pkg::PULSE_ZERO;
		end
	end

	property p_pulse_len;
		@(posedge clk) disable iff (!resetn)
		$fell(pulse) |-> ($past(width) == (wdg_pkg::PULSE_LOAD - 7'h01));
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("reset pulse not 96 cycles long");
endmodule

//--- hw/wdg_watchdog_timer.sv
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
// How it works
// - halve select: watchdog clock is osc/2
// - otherwise osc/2, or osc in double speed
// - disabled and idle after any reset
// - arm by writing 1Eh then E1h
// - each completed sequence clears the count
// - once armed, nothing but reset stops it; here its own overflow also drops ARMED
// - overflow forces reset, 96-period high pulse
// - 14-bit prescaler then 7-bit counter
// - period is 6*(2^(14+sel)-1) watchdog clocks
// - each select step doubles the period
// - keeps counting through idle mode
// - power-down freezes count, wake resumes it
// - reset wake from power-down clears, disables
// - service register is write-only, control only
// - upper period bits indeterminate, write zero
// - time-out select resets to zero
module wdg_watchdog_timer #(
	parameter int PRESCALE_BITS = wdg_pkg::PRESC_W // shorten in sim
) (
	input  wire logic       CLK,
	input  wire logic       RESETN,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	input  wire logic       WD_CLOCK_HALVE_SELECT,
	input  wire logic       DOUBLE_SPEED_MODE,
	input  wire logic       POWER_DOWN,
	output logic [7:0]      RDATA,
	output logic            RST_OUT,
	output logic            ARMED
);
	// ------------------------------------------------------------
	// internal state
	// ------------------------------------------------------------
	logic [2:0]                 timeout_select; // period field
	wdg_pkg::wdg_seq_t          seq_state;      // sequence detector
	wdg_pkg::wdg_seq_t          next_seq_state;
	logic [wdg_pkg::PRESC_W-1:0] presc;         // low stage
	logic [wdg_pkg::PROG_W-1:0]  prog;          // high stage
	logic                       tick;           // one count step
	logic                       overflow;       // one-cycle pulse
	logic                       service_wr;     // write to service
	logic                       period_wr;      // write to period
	logic                       arm_now;        // sequence complete
	logic                       run;            // divider running
	logic [wdg_pkg::CNT_W-1:0]  count;          // joined count
	logic [wdg_pkg::CNT_W:0]    lim_bit;        // 2^(n) one-hot
	logic [wdg_pkg::CNT_W:0]    lim_wide;       // 2^(n)-2
	logic [wdg_pkg::CNT_W-1:0]  limit;          // last count before overflow
	logic                       at_limit;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	assign service_wr = WR && (ADDR == wdg_pkg::SERVICE_ADDR);
	assign period_wr  = WR && (ADDR == wdg_pkg::PERIOD_ADDR);

	// ------------------------------------------------------------
	// service sequence detector
	// ------------------------------------------------------------

	// any other byte breaks the pair; a fresh first byte restarts
	always_comb begin
		next_seq_state = seq_state;
		arm_now        = 1'b0;
		if (service_wr) begin
			case (seq_state)
				wdg_pkg::SEQ_IDLE: begin
					if (WDATA == wdg_pkg::ARM_FIRST) begin
						next_seq_state = wdg_pkg::SEQ_FIRST;
					end
				end
				wdg_pkg::SEQ_FIRST: begin
					if (WDATA == wdg_pkg::ARM_SECOND) begin
						arm_now        = 1'b1;
						next_seq_state = wdg_pkg::SEQ_IDLE;
					end else if (WDATA == wdg_pkg::ARM_FIRST) begin
						next_seq_state = wdg_pkg::SEQ_FIRST;
					end else begin
						next_seq_state = wdg_pkg::SEQ_IDLE;
					end
				end
				default: begin
					next_seq_state = wdg_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	// written byte is not stored; it only steers the detector
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			seq_state <= wdg_pkg::SEQ_IDLE;
		end else begin
			seq_state <= next_seq_state;
		end
	end

	// ------------------------------------------------------------
	// arm flag
	// ------------------------------------------------------------

	// only reset or our own overflow (which resets the chip)
	// drop it; a reset ending power-down lands here too
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ARMED <= 1'b0;
		end else if (overflow) begin
			ARMED <= 1'b0;
		end else if (arm_now) begin
			ARMED <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// period register
	// ------------------------------------------------------------

	// upper bits are dropped on write, software keeps them zero
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			timeout_select <= wdg_pkg::SEL_RESET;
		end else if (period_wr) begin
			timeout_select <=
				WDATA[wdg_pkg::SEL_LSB +: wdg_pkg::SEL_W];
		end
	end

	// ------------------------------------------------------------
	// step generator
	// ------------------------------------------------------------

	// idle mode does not stop it; power-down does
	assign run = ARMED && !POWER_DOWN;

	wdg_tick_gen u_tick (
		.clk          (CLK),
		.resetn       (RESETN),
		.run          (run),
		.clear        (arm_now || overflow),
		.halve_select (WD_CLOCK_HALVE_SELECT),
		.double_speed (DOUBLE_SPEED_MODE),
		.tick         (tick)
	);

	// ------------------------------------------------------------
	// prescaler and programmable counter
	// ------------------------------------------------------------
	assign count = {prog, presc};

	// terminal count 2^(prescale+sel)-1, doubling per select step;
	// limit sits one below it, so the step that would land on the
	// terminal count is the one that overflows: 2^n-1 steps in all
	assign lim_bit  = {{wdg_pkg::CNT_W{1'b0}}, 1'b1}
		<< (PRESCALE_BITS + int'(timeout_select));
	assign lim_wide = lim_bit - {{(wdg_pkg::CNT_W-1){1'b0}}, 2'h2};
	assign limit    = lim_wide[wdg_pkg::CNT_W-1:0];
	assign at_limit = (count == limit);

	// prescaler carries into the programmable stage
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			presc <= '0;
			prog  <= '0;
		end else if (arm_now || overflow) begin
			presc <= '0;
			prog  <= '0;
		end else if (tick && !at_limit) begin
			presc <= presc + 1'b1;
			if (&presc) begin
				prog <= prog + 1'b1;
			end
		end
	end

	// overflow when a step lands on the terminal count
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			overflow <= 1'b0;
		end else begin
			overflow <= tick && at_limit && ARMED
				&& !arm_now;
		end
	end

	// ------------------------------------------------------------
	// reset pulse
	// ------------------------------------------------------------
	wdg_pulse_gen u_pulse (
		.clk    (CLK),
		.resetn (RESETN),
		.start  (overflow),
		.pulse  (RST_OUT)
	);

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------

	// data valid only in the cycle after the strobe; the service
	// register is write-only and reads as zero
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= wdg_pkg::READ_ZERO;
		end else if (RD && (ADDR == wdg_pkg::PERIOD_ADDR)) begin
			RDATA <= {ARMED, wdg_pkg::PAD_ZERO, timeout_select};
		end else begin
			RDATA <= wdg_pkg::READ_ZERO;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	property p_idle_no_count;
		!ARMED |=> (count == '0);
	endproperty
	a_idle_no_count: assert property (p_idle_no_count)
		else $error("count moved while disabled");

	property p_arm_seq;
		(service_wr && WDATA == wdg_pkg::ARM_FIRST
			&& !period_wr)
		##1 (service_wr && WDATA == wdg_pkg::ARM_SECOND)
		|=> ARMED && (count == '0);
	endproperty
	a_arm_seq: assert property (p_arm_seq)
		else $error("sequence did not arm");

	property p_service_clears;
		(ARMED && arm_now) |=> (count == '0) && ARMED;
	endproperty
	a_service_clears: assert property (p_service_clears)
		else $error("service did not clear count");

	property p_stays_armed;
		(ARMED && !overflow) |=> ARMED;
	endproperty
	a_stays_armed: assert property (p_stays_armed)
		else $error("watchdog stopped without reset");

	property p_overflow_pulse;
		overflow |=> RST_OUT [*8] ##1 RST_OUT;
	endproperty
	a_overflow_pulse: assert property (p_overflow_pulse)
		else $error("no reset pulse after overflow");

	property p_limit_hit;
		(ARMED && tick && at_limit && !arm_now) |=> overflow;
	endproperty
	a_limit_hit: assert property (p_limit_hit)
		else $error("terminal count missed");

	// a step issued on the entry edge still lands, and may raise
	// an overflow; the hold starts one cycle into power-down
	property p_pd_hold;
		(POWER_DOWN && $past(POWER_DOWN) && !service_wr && !overflow)
		|=> $stable(count);
	endproperty
	a_pd_hold: assert property (p_pd_hold)
		else $error("count moved in power-down");

	property p_break_seq;
		(seq_state == wdg_pkg::SEQ_FIRST && service_wr
			&& WDATA != wdg_pkg::ARM_SECOND)
		|=> $stable(ARMED) && !$past(arm_now);
	endproperty
	a_break_seq: assert property (p_break_seq)
		else $error("broken sequence acted");

	property p_sel_reset;
		$rose(RESETN) |-> (timeout_select == wdg_pkg::SEL_RESET);
	endproperty
	a_sel_reset: assert property (p_sel_reset)
		else $error("select not zero after reset");

	property p_read_late;
		(RD && ADDR == wdg_pkg::PERIOD_ADDR)
		|=> (RDATA[2:0] == $past(timeout_select));
	endproperty
	a_read_late: assert property (p_read_late)
		else $error("period read back wrong");

	// service register and holes read as zero
	property p_read_other;
		(RD && ADDR != wdg_pkg::PERIOD_ADDR)
		|=> (RDATA == wdg_pkg::READ_ZERO);
	endproperty
	a_read_other: assert property (p_read_other)
		else $error("unmapped read not zero");

	// read data stand for one cycle only
	property p_read_quiet;
		!RD |=> (RDATA == wdg_pkg::READ_ZERO);
	endproperty
	a_read_quiet: assert property (p_read_quiet)
		else $error("read data held too long");

	// spare period bits never echo what was written
	property p_read_pad;
		(RD && ADDR == wdg_pkg::PERIOD_ADDR)
		|=> (RDATA[wdg_pkg::SEL_W +: 4] == wdg_pkg::PAD_ZERO);
	endproperty
	a_read_pad: assert property (p_read_pad)
		else $error("spare period bits not zero");

	// overflow starts the pulse, drops the arm and clears the count
	property p_overflow_disarm;
		overflow |=> RST_OUT && !ARMED && (count == '0);
	endproperty
	a_overflow_disarm: assert property (p_overflow_disarm)
		else $error("overflow left watchdog running");

	// a lone second byte must not arm
	property p_lone_second;
		(service_wr && seq_state == wdg_pkg::SEQ_IDLE && !ARMED)
		|=> !ARMED;
	endproperty
	a_lone_second: assert property (p_lone_second)
		else $error("watchdog armed without first byte");

	// only the low field of a period write is kept
	property p_sel_write;
		period_wr
		|=> (timeout_select == $past(WDATA[wdg_pkg::SEL_W-1:0]));
	endproperty
	a_sel_write: assert property (p_sel_write)
		else $error("period field not stored");

	// count moves only on a step, an arm or an overflow
	property p_count_steps;
		(!tick && !arm_now && !overflow) |=> $stable(count);
	endproperty
	a_count_steps: assert property (p_count_steps)
		else $error("count moved without a step");

	// detector state stays one-hot
	property p_seq_onehot;
		$onehot(seq_state);
	endproperty
	a_seq_onehot: assert property (p_seq_onehot)
		else $error("sequence detector state broken");

	c_armed:    cover property (arm_now && !ARMED);
	c_serviced: cover property (arm_now && ARMED);
	c_overflow: cover property (overflow);
	c_pd_hold:  cover property (ARMED && POWER_DOWN);
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// self-checking bench for the watchdog
// ----------------------------------------------------------------
module tb_top;
	localparam int PB = 2; // short prescaler keeps runs brief

	logic       clk;       // 125 MHz oscillator
	logic       resetn;    // async, active low
	logic [7:0] addr;      // register address
	logic [7:0] wdata;     // write data
	logic       wr_s;      // write strobe
	logic       rd_s;      // read strobe
	logic       half;      // fixed osc/2 watchdog clock
	logic       dbl;       // double-speed core mode
	logic       pd;        // power-down
	logic [7:0] rdata;     // read data
	logic       rst_out;   // forced chip reset
	logic       armed;     // watchdog running
	int         err_count;
	int         checks_done;
	int         cyc;       // hang guard
	logic [7:0] d;         // last read value
	int         n;         // measured cycles

	wdg_watchdog_timer #(.PRESCALE_BITS(PB)) wdg_watchdog_timer_i (
		.CLK                   (clk),
		.RESETN                (resetn),
		.ADDR                  (addr),
		.WDATA                 (wdata),
		.WR                    (wr_s),
		.RD                    (rd_s),
		.WD_CLOCK_HALVE_SELECT (half),
		.DOUBLE_SPEED_MODE     (dbl),
		.POWER_DOWN            (pd),
		.RDATA                 (rdata),
		.RST_OUT               (rst_out),
		.ARMED                 (armed)
	);

	// ------------------------------------------------------------
	// clock, hang guard, verdict
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ceiling well above the roughly 18000 cycles the tests need
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			test_done();
		end
	end

	task automatic test_done();
		if (err_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ------------------------------------------------------------
	// compares and bus cycles
	// ------------------------------------------------------------
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// cycle counts: exact phase of the first step is left open
	task automatic chkr(input int got, input int lo, input int hi);
		checks_done++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, lo);
		end
	endtask

	// strobe stays high so writes can follow with no gap
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr_s  <= 1'b1;
		rd_s  <= 1'b0;
		addr  <= a;
		wdata <= v;
	endtask

	task automatic idle();
		@(posedge clk);
		wr_s <= 1'b0;
		rd_s <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd_s <= 1'b1;
		wr_s <= 1'b0;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic arm();
		wr(wdg_pkg::SERVICE_ADDR, wdg_pkg::ARM_FIRST);
		wr(wdg_pkg::SERVICE_ADDR, wdg_pkg::ARM_SECOND);
		idle();
	endtask

	// edges until the reset pulse shows, bounded
	task automatic wait_rst(output int c);
		c = 0;
		while (rst_out !== 1'b1 && c < 9000) begin
			@(posedge clk);
			#1 c++;
		end
	endtask

	// let the pulse run out and check its length
	task automatic pulse_end();
		int p;
		p = 0;
		while (rst_out === 1'b1 && p < 200) begin
			@(posedge clk);
			#1 p++;
		end
		chkr(p, wdg_pkg::RST_PULSE_OSC, wdg_pkg::RST_PULSE_OSC);
		chk8({7'h00, armed}, 8'h00);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk8({6'h00, armed, rst_out}, 8'h00);
		rd(wdg_pkg::PERIOD_ADDR, d);
		chk8(d & 8'h07, 8'h00);
		rd(wdg_pkg::SERVICE_ADDR, d);
		chk8(d, wdg_pkg::READ_ZERO);
		rd(8'h10, d);
		chk8(d, wdg_pkg::READ_ZERO);
		repeat (3000) @(posedge clk);
		#1 chk8({6'h00, armed, rst_out}, 8'h00);
	endtask

	// broken pairs must not arm; once armed, stray writes do not stop it, only the overflow does
	task automatic t_seq();
		wr(wdg_pkg::SERVICE_ADDR, wdg_pkg::ARM_FIRST);
		wr(wdg_pkg::SERVICE_ADDR, 8'h55);
		wr(wdg_pkg::SERVICE_ADDR, wdg_pkg::ARM_SECOND);
		wr(wdg_pkg::SERVICE_ADDR, wdg_pkg::ARM_SECOND);
		idle();
		#1 chk8({7'h00, armed}, 8'h00);
		arm();
		#1 chk8({7'h00, armed}, 8'h01);
		wr(wdg_pkg::SERVICE_ADDR, 8'h00);
		wr(wdg_pkg::SERVICE_ADDR, wdg_pkg::ARM_FIRST);
		wr(wdg_pkg::SERVICE_ADDR, 8'h00);
		wr(wdg_pkg::PERIOD_ADDR, 8'h00);
		idle();
		#1 chk8({7'h00, armed}, 8'h01);
		wait_rst(n);
		pulse_end();
	endtask

	// full time-out for one select value and clock mode
	task automatic t_to(input int s, input logic h, input logic x);
		int dv;
		int e;
		half <= h;
		dbl  <= x;
		dv = (x && !h) ? 1 : 2;
		e = 6 * ((1 << (PB + s)) - 1) * dv;
		wr(wdg_pkg::PERIOD_ADDR, 8'(s));
		idle();
		rd(wdg_pkg::PERIOD_ADDR, d);
		chk8(d & 8'h07, 8'(s));
		arm();
		wait_rst(n);
		chkr(n, e - 1, e + 4);
		pulse_end();
	endtask

	// a second service restarts the full period
	task automatic t_service();
		half <= 1'b0;
		dbl  <= 1'b0;
		wr(wdg_pkg::PERIOD_ADDR, 8'h01);
		arm();
		repeat (60) @(posedge clk);
		arm();
		wait_rst(n);
		chkr(n, 83, 88);
		pulse_end();
	endtask

	// power-down holds the count, wake resumes it
	task automatic t_pd();
		arm();
		repeat (40) @(posedge clk);
		pd <= 1'b1;
		repeat (500) @(posedge clk);
		#1 chk8({6'h00, armed, rst_out}, 8'h02);
		@(posedge clk);
		pd <= 1'b0;
		wait_rst(n);
		chkr(n, 40, 50);
		pulse_end();
	endtask

	// reset during power-down clears and disables
	task automatic t_pd_reset();
		arm();
		repeat (20) @(posedge clk);
		arm();
		pd <= 1'b1;
		repeat (10) @(posedge clk);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		pd     <= 1'b0;
		repeat (300) @(posedge clk);
		#1 chk8({6'h00, armed, rst_out}, 8'h00);
		rd(wdg_pkg::PERIOD_ADDR, d);
		chk8(d & 8'h07, 8'h00);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		resetn      = 1'b0;
		addr        = 8'h00;
		wdata       = 8'h00;
		wr_s        = 1'b0;
		rd_s        = 1'b0;
		half        = 1'b0;
		dbl         = 1'b0;
		pd          = 1'b0;
		err_count   = 0;
		checks_done = 0;
		cyc         = 0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_seq();
		for (int s = 0; s < 8; s++) begin
			t_to(s, 1'b0, 1'b0);
		end
		t_to(0, 1'b0, 1'b1);
		t_to(0, 1'b1, 1'b1);
		t_to(2, 1'b1, 1'b0);
		t_service();
		t_pd();
		t_pd_reset();
		test_done();
	end
endmodule
